// *** rtl/ocb_regs.svh ***
// register offsets, field positions, reset values and timing figures of the oscillator bank
`ifndef OCB_REGS_SVH
`define OCB_REGS_SVH

`define OCB_ADDR_W 12
`define OCB_FAST_OFF 12'h018
`define OCB_EXT_OFF 12'h01c
`define OCB_SLOW_OFF 12'h020
`define OCB_SUPV_OFF 12'h02c

`define OCB_STABLE_LO 15
`define OCB_DIV_MSB 14
`define OCB_DIV_LSB 11
`define OCB_FTRIM_MSB 10
`define OCB_SWAIT_MSB 11
`define OCB_SWAIT_LSB 10
`define OCB_STRIM_MSB 9
`define OCB_EXT_STABLE 19
`define OCB_WIN_MSB 18
`define OCB_WIN_LSB 8
`define OCB_FLT_BIT 7
`define OCB_MODE_BIT 6
`define OCB_EWAIT_MSB 5
`define OCB_EWAIT_LSB 4
`define OCB_BAND_MSB 3
`define OCB_BAND_LSB 2
`define OCB_DRIVE_MSB 1
`define OCB_SUPV_EN_BIT 0
`define OCB_SUPV_RUNF_BIT 1
`define OCB_SUPV_STARTF_BIT 2

`define OCB_EXT_RESET 32'h0007_ff22
`define OCB_DIV_RESET 4'h5
`define OCB_FTRIM_RESET 11'h400
`define OCB_SWAIT_RESET 2'h3
`define OCB_STRIM_RESET 10'h200

`define OCB_DIV_BY1 4'h6
`define OCB_DIV_BY2 4'h8
`define OCB_DIV_BY4 4'h9
`define OCB_DIV_BY6 4'h5
`define OCB_DIV_BY8 4'hb
`define OCB_DIV_BY10 4'hc
`define OCB_DIV_BY12 4'hd
`define OCB_DIV_BY14 4'he
`define OCB_DIV_BY16 4'hf

`define OCB_SWAIT_0 9'h006
`define OCB_SWAIT_1 9'h012
`define OCB_SWAIT_2 9'h042
`define OCB_SWAIT_3 9'h102

`define OCB_RUN_MIN_EDGES 18'h2_0000
`define OCB_CLK_MHZ 125
`define OCB_START_LIM_A_MS 65
`define OCB_START_LIM_B_MS 65
`define OCB_START_LIM_C_MS 130
`define OCB_START_LIM_D_MS 130

`endif

// *** rtl/ocb_pkg.sv ***
// types shared by the oscillator bank
package ocb_pkg;
	typedef enum logic [1:0] {
		EXT_OFF,
		EXT_SETTLE,
		EXT_STABLE,
		EXT_START_FAIL
	} ocb_ext_state_t;
endpackage

// *** rtl/ocb_oscillator_control_bank.sv ***
// oscillator control bank: trim, divide, settle and external clock supervision
//
// Notes on behaviour
// - fast oscillator register bit 15 reads 1 once fast oscillator has settled.
// - four-bit selector divides fast oscillator by 1,2,4,6,8,10,12,14,16; default 6.
// - eleven-bit trim field steers fast oscillator frequency, about 0.2% per step.
// - slow oscillator register bit 15 reads 1 once slow oscillator has settled.
// - two-bit selector sets slow settle: 6, 18, 66 or 258 slow cycles.
// - ten-bit trim field steers slow oscillator frequency.
// - external register bit 19 reads 1 once external fast clock has settled.
// - eleven-bit run failure window in slow periods; software never leaves it zero.
// - bit 7 enables input noise filter; external clock then at most 8 MHz.
// - bit 6 picks crystal mode (0) or direct pin clock (1).
// - two-bit selector sets settle count: 8192, 32768, 131072 or 262144 clocks.
// - with supervision on, start fails when count not reached within time limit.
// - two-bit band selector tells crystal oscillator its frequency range.
// - two-bit drive strength, weakest 00 to strongest 11, default 10.
// - external register resets to 0x0007_ff22.
// - running external clock fails below 0x20000 edges per programmed window.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "ocb_regs.svh"

module ocb_oscillator_control_bank #(
	parameter int FAST_SETTLE_EDGES = 16,
	parameter int EXT_WAIT_0 = 8192,
	parameter int EXT_WAIT_1 = 32768,
	parameter int EXT_WAIT_2 = 131072,
	parameter int EXT_WAIT_3 = 262144,
	parameter int START_LIM_A_CYC = `OCB_START_LIM_A_MS * 1000 * `OCB_CLK_MHZ,
	parameter int START_LIM_B_CYC = `OCB_START_LIM_B_MS * 1000 * `OCB_CLK_MHZ,
	parameter int START_LIM_C_CYC = `OCB_START_LIM_C_MS * 1000 * `OCB_CLK_MHZ,
	parameter int START_LIM_D_CYC = `OCB_START_LIM_D_MS * 1000 * `OCB_CLK_MHZ
)(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// oscillator enables from the system control block
	input wire logic fast_osc_enable,
	input wire logic slow_osc_enable,
	input wire logic ext_osc_enable,
	// raw oscillator clocks
	input wire logic internal_fast_oscillator,
	input wire logic internal_slow_clock,
	input wire logic crystal_osc_clk,
	input wire logic oscillator_input_pin,
	// analog controls
	output logic [10:0] fast_osc_trim,
	output logic [9:0] slow_osc_trim,
	output logic [1:0] crystal_band_select,
	output logic [1:0] crystal_drive_strength,
	output logic ext_input_mode,
	output logic input_noise_filter_enable,
	// clock and status
	output logic internal_fast_clock,
	output logic fast_stable,
	output logic slow_stable,
	output logic ext_stable,
	output logic ext_run_fail,
	output logic ext_start_fail
);

	logic [3:0] div_reg;
	logic [10:0] ftrim_reg;
	logic [1:0] swait_reg;
	logic [9:0] strim_reg;
	logic [10:0] win_reg;
	logic flt_reg;
	logic mode_reg;
	logic [1:0] ewait_reg;
	logic [1:0] band_reg;
	logic [1:0] drive_reg;
	logic supv_reg;
	logic wr_pend_reg;
	logic [`OCB_ADDR_W-1:0] addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_next;
	logic take;

	logic [2:0] osc_raw;
	logic [2:0] filt_on;
	logic [2:0] sy1_reg;
	logic [2:0] sy2_reg;
	logic [2:0] sy3_reg;
	logic [2:0] sy4_reg;
	logic [2:0] lvl_reg;
	logic [2:0] rise;

	logic [4:0] fset_reg;
	logic fstable_reg;
	logic [8:0] sset_reg;
	logic [8:0] swait_target;
	logic sstable_reg;
	logic [2:0] fdiv_cnt_reg;
	logic [3:0] fhalf;
	logic fclk_reg;

	ocb_pkg::ocb_ext_state_t ext_state_reg;
	logic [18:0] ext_edges_reg;
	logic [18:0] ext_target;
	logic [23:0] start_time_reg;
	logic [23:0] start_lim;
	logic [10:0] win_cnt_reg;
	logic [17:0] run_edges_reg;
	logic run_fail_reg;

	// ahb-lite: writes stall one cycle so a following read sees the new value
	assign take = hsel & htrans[1] & hready;
	assign hreadyout = clk_en & ~wr_pend_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_pend_reg <= 1'b0;
			addr_reg <= '0;
			hrdata_reg <= '0;
		end
		else if (clk_en)
		begin
			if (wr_pend_reg)
				wr_pend_reg <= 1'b0;
			else if (take)
			begin
				wr_pend_reg <= hwrite;
				addr_reg <= {haddr[`OCB_ADDR_W-1:2], 2'b00};
				hrdata_reg <= hwrite ? '0 : rd_next;
			end
		end
	end

	always_comb
	begin
		rd_next = '0;
		case ({haddr[`OCB_ADDR_W-1:2], 2'b00})
			`OCB_FAST_OFF:
			begin
				rd_next[`OCB_STABLE_LO] = fstable_reg;
				rd_next[`OCB_DIV_MSB:`OCB_DIV_LSB] = div_reg;
				rd_next[`OCB_FTRIM_MSB:0] = ftrim_reg;
			end
			`OCB_SLOW_OFF:
			begin
				rd_next[`OCB_STABLE_LO] = sstable_reg;
				rd_next[`OCB_SWAIT_MSB:`OCB_SWAIT_LSB] = swait_reg;
				rd_next[`OCB_STRIM_MSB:0] = strim_reg;
			end
			`OCB_EXT_OFF:
			begin
				rd_next[`OCB_EXT_STABLE] = ext_stable;
				rd_next[`OCB_WIN_MSB:`OCB_WIN_LSB] = win_reg;
				rd_next[`OCB_FLT_BIT] = flt_reg;
				rd_next[`OCB_MODE_BIT] = mode_reg;
				rd_next[`OCB_EWAIT_MSB:`OCB_EWAIT_LSB] = ewait_reg;
				rd_next[`OCB_BAND_MSB:`OCB_BAND_LSB] = band_reg;
				rd_next[`OCB_DRIVE_MSB:0] = drive_reg;
			end
			`OCB_SUPV_OFF:
			begin
				rd_next[`OCB_SUPV_EN_BIT] = supv_reg;
				rd_next[`OCB_SUPV_RUNF_BIT] = run_fail_reg;
				rd_next[`OCB_SUPV_STARTF_BIT] = (ext_state_reg == ocb_pkg::EXT_START_FAIL);
			end
			default: rd_next = '0;
		endcase
	end

	// register fields; reserved and read-only bits ignore writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_reg <= `OCB_DIV_RESET;
			ftrim_reg <= `OCB_FTRIM_RESET;
			swait_reg <= `OCB_SWAIT_RESET;
			strim_reg <= `OCB_STRIM_RESET;
			win_reg <= 11'(`OCB_EXT_RESET >> `OCB_WIN_LSB);
			flt_reg <= 1'(`OCB_EXT_RESET >> `OCB_FLT_BIT);
			mode_reg <= 1'(`OCB_EXT_RESET >> `OCB_MODE_BIT);
			ewait_reg <= 2'(`OCB_EXT_RESET >> `OCB_EWAIT_LSB);
			band_reg <= 2'(`OCB_EXT_RESET >> `OCB_BAND_LSB);
			drive_reg <= 2'(`OCB_EXT_RESET);
			supv_reg <= 1'b0;
		end
		else if (clk_en && wr_pend_reg)
		begin
			case (addr_reg)
				`OCB_FAST_OFF:
				begin
					div_reg <= hwdata[`OCB_DIV_MSB:`OCB_DIV_LSB];
					ftrim_reg <= hwdata[`OCB_FTRIM_MSB:0];
				end
				`OCB_SLOW_OFF:
				begin
					swait_reg <= hwdata[`OCB_SWAIT_MSB:`OCB_SWAIT_LSB];
					strim_reg <= hwdata[`OCB_STRIM_MSB:0];
				end
				`OCB_EXT_OFF:
				begin
					win_reg <= hwdata[`OCB_WIN_MSB:`OCB_WIN_LSB];
					flt_reg <= hwdata[`OCB_FLT_BIT];
					mode_reg <= hwdata[`OCB_MODE_BIT];
					ewait_reg <= hwdata[`OCB_EWAIT_MSB:`OCB_EWAIT_LSB];
					band_reg <= hwdata[`OCB_BAND_MSB:`OCB_BAND_LSB];
					drive_reg <= hwdata[`OCB_DRIVE_MSB:0];
				end
				`OCB_SUPV_OFF: supv_reg <= hwdata[`OCB_SUPV_EN_BIT];
				default: ;
			endcase
		end
	end

	assign fast_osc_trim = ftrim_reg;
	assign slow_osc_trim = strim_reg;
	assign crystal_band_select = band_reg;
	assign crystal_drive_strength = drive_reg;
	assign ext_input_mode = mode_reg;
	assign input_noise_filter_enable = flt_reg;

	// oscillator sampling; index 0 fast, 1 slow, 2 external
	assign osc_raw[0] = internal_fast_oscillator;
	assign osc_raw[1] = internal_slow_clock;
	assign osc_raw[2] = mode_reg ? oscillator_input_pin : crystal_osc_clk;
	assign filt_on = {flt_reg, 2'b00};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			logic agree;
			// the filter asks a fourth stage to agree as well
			assign agree = (sy2_reg[gi] == sy3_reg[gi]) &&
				(!filt_on[gi] || sy3_reg[gi] == sy4_reg[gi]);
			assign rise[gi] = agree & sy3_reg[gi] & ~lvl_reg[gi];
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					sy1_reg[gi] <= 1'b0;
					sy2_reg[gi] <= 1'b0;
					sy3_reg[gi] <= 1'b0;
					sy4_reg[gi] <= 1'b0;
					lvl_reg[gi] <= 1'b0;
				end
				else if (clk_en)
				begin
					sy1_reg[gi] <= osc_raw[gi];
					sy2_reg[gi] <= sy1_reg[gi];
					sy3_reg[gi] <= sy2_reg[gi];
					sy4_reg[gi] <= sy3_reg[gi];
					if (agree)
						lvl_reg[gi] <= sy3_reg[gi];
				end
			end
		end
	endgenerate

	// internal oscillator settling
	always_comb
	begin
		case (swait_reg)
			2'b00: swait_target = `OCB_SWAIT_0;
			2'b01: swait_target = `OCB_SWAIT_1;
			2'b10: swait_target = `OCB_SWAIT_2;
			default: swait_target = `OCB_SWAIT_3;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fset_reg <= '0;
			fstable_reg <= 1'b0;
			sset_reg <= '0;
			sstable_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!fast_osc_enable)
			begin
				fset_reg <= '0;
				fstable_reg <= 1'b0;
			end
			else if (fset_reg == 5'(FAST_SETTLE_EDGES))
				fstable_reg <= 1'b1;
			else if (rise[0])
				fset_reg <= fset_reg + 5'd1;
			if (!slow_osc_enable)
			begin
				sset_reg <= '0;
				sstable_reg <= 1'b0;
			end
			else if (sset_reg >= swait_target)
				sstable_reg <= 1'b1;
			else if (rise[1])
				sset_reg <= sset_reg + 9'd1;
		end
	end

	// fast clock divider: toggle every half period counted in oscillator edges
	always_comb
	begin
		case (div_reg)
			`OCB_DIV_BY1: fhalf = 4'd0;
			`OCB_DIV_BY2: fhalf = 4'd1;
			`OCB_DIV_BY4: fhalf = 4'd2;
			`OCB_DIV_BY8: fhalf = 4'd4;
			`OCB_DIV_BY10: fhalf = 4'd5;
			`OCB_DIV_BY12: fhalf = 4'd6;
			`OCB_DIV_BY14: fhalf = 4'd7;
			`OCB_DIV_BY16: fhalf = 4'd8;
			default: fhalf = 4'd3;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fdiv_cnt_reg <= '0;
			fclk_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!fast_osc_enable)
			begin
				fdiv_cnt_reg <= '0;
				fclk_reg <= 1'b0;
			end
			else if (fhalf == 4'd0)
				fclk_reg <= lvl_reg[0];
			else if (rise[0])
			begin
				if ({1'b0, fdiv_cnt_reg} >= fhalf - 4'd1)
				begin
					fdiv_cnt_reg <= '0;
					fclk_reg <= ~fclk_reg;
				end
				else
					fdiv_cnt_reg <= fdiv_cnt_reg + 3'd1;
			end
		end
	end

	// external clock start-up
	always_comb
	begin
		case (ewait_reg)
			2'b00:
			begin
				ext_target = 19'(EXT_WAIT_0);
				start_lim = 24'(START_LIM_A_CYC);
			end
			2'b01:
			begin
				ext_target = 19'(EXT_WAIT_1);
				start_lim = 24'(START_LIM_B_CYC);
			end
			2'b10:
			begin
				ext_target = 19'(EXT_WAIT_2);
				start_lim = 24'(START_LIM_C_CYC);
			end
			default:
			begin
				ext_target = 19'(EXT_WAIT_3);
				start_lim = 24'(START_LIM_D_CYC);
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ext_state_reg <= ocb_pkg::EXT_OFF;
		else if (clk_en)
		begin
			case (ext_state_reg)
				ocb_pkg::EXT_OFF:
					if (ext_osc_enable)
						ext_state_reg <= ocb_pkg::EXT_SETTLE;
				ocb_pkg::EXT_SETTLE:
					if (!ext_osc_enable)
						ext_state_reg <= ocb_pkg::EXT_OFF;
					else if (ext_edges_reg >= ext_target)
						ext_state_reg <= ocb_pkg::EXT_STABLE;
					else if (supv_reg && start_time_reg >= start_lim)
						ext_state_reg <= ocb_pkg::EXT_START_FAIL;
				ocb_pkg::EXT_STABLE:
					if (!ext_osc_enable)
						ext_state_reg <= ocb_pkg::EXT_OFF;
				ocb_pkg::EXT_START_FAIL:
					if (!ext_osc_enable || !supv_reg)
						ext_state_reg <= ocb_pkg::EXT_OFF;
				default: ext_state_reg <= ocb_pkg::EXT_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_edges_reg <= '0;
			start_time_reg <= '0;
		end
		else if (clk_en)
		begin
			if (ext_state_reg != ocb_pkg::EXT_SETTLE)
			begin
				ext_edges_reg <= '0;
				start_time_reg <= '0;
			end
			else
			begin
				if (rise[2])
					ext_edges_reg <= ext_edges_reg + 19'd1;
				start_time_reg <= start_time_reg + 24'd1;
			end
		end
	end

	// run-time supervision: edges per window of slow clock periods
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			win_cnt_reg <= '0;
			run_edges_reg <= '0;
			run_fail_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!supv_reg || !ext_osc_enable)
				run_fail_reg <= 1'b0;
			if (ext_state_reg != ocb_pkg::EXT_STABLE || !supv_reg)
			begin
				win_cnt_reg <= '0;
				run_edges_reg <= '0;
			end
			else if (rise[1] && win_cnt_reg == win_reg - 11'd1)
			begin
				if (run_edges_reg < `OCB_RUN_MIN_EDGES)
					run_fail_reg <= 1'b1;
				win_cnt_reg <= '0;
				run_edges_reg <= {17'd0, rise[2]};
			end
			else
			begin
				if (rise[1])
					win_cnt_reg <= win_cnt_reg + 11'd1;
				if (rise[2] && run_edges_reg < `OCB_RUN_MIN_EDGES)
					run_edges_reg <= run_edges_reg + 18'd1;
			end
		end
	end

	assign internal_fast_clock = fclk_reg;
	assign fast_stable = fstable_reg;
	assign slow_stable = sstable_reg;
	assign ext_stable = (ext_state_reg == ocb_pkg::EXT_STABLE) && !run_fail_reg;
	assign ext_run_fail = run_fail_reg;
	assign ext_start_fail = (ext_state_reg == ocb_pkg::EXT_START_FAIL);

endmodule

// *** test/ocb_ext_clock_model.sv ***
// behavioural external clock source feeding both the crystal and the pin inputs
`timescale 1ns/1ps
module ocb_ext_clock_model (
	// control from the bench
	input wire logic run,
	input wire logic [7:0] half_ns,
	// clock towards the block
	output logic ext_clk
);
	initial ext_clk = 1'b0;
	// the clock stands still low while stopped, so a dead source is seen as no edges
	always
	begin
		if (run)
			#(half_ns) ext_clk = ~ext_clk;
		else
		begin
			ext_clk = 1'b0;
			@(posedge run);
		end
	end
endmodule

// *** test/ocb_checker_sva.sv ***
// port assertions for the oscillator control bank
`timescale 1ns/1ps
module ocb_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// status and fields
	input wire logic fast_osc_enable,
	input wire logic ext_osc_enable,
	input wire logic fast_stable,
	input wire logic slow_stable,
	input wire logic ext_stable,
	input wire logic ext_run_fail,
	input wire logic ext_start_fail,
	input wire logic [1:0] crystal_band_select,
	input wire logic [1:0] crystal_drive_strength
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic rd_take;
	logic wr_take;
	assign rd_take = hsel && htrans[1] && hready && clk_en && !hwrite;
	assign wr_take = hsel && htrans[1] && hready && clk_en && hwrite;
	AST_RD_FAST: assert property (rd_take && haddr[11:0] == 12'h018 |=>
		hrdata[15] == $past(fast_stable) && hrdata[31:16] == 16'h0000) else $error("fast flag");
	AST_RD_SLOW: assert property (rd_take && haddr[11:0] == 12'h020 |=>
		hrdata[15] == $past(slow_stable) && hrdata[31:16] == 16'h0000) else $error("slow flag");
	AST_RD_EXT: assert property (rd_take && haddr[11:0] == 12'h01c |=>
		hrdata[19] == $past(ext_stable) && hrdata[31:20] == 12'h000) else $error("ext flag");
	AST_FAST_OFF: assert property (!fast_osc_enable [*2] |-> !fast_stable)
		else $error("fast stable while off");
	AST_EXT_OFF: assert property (!ext_osc_enable [*2] |-> !ext_stable && !ext_run_fail)
		else $error("ext status while off");
	AST_RUN_FAIL: assert property (ext_run_fail |-> !ext_stable)
		else $error("stable with run failure");
	AST_START_FAIL: assert property (ext_start_fail |-> !ext_stable)
		else $error("stable with start failure");
	AST_BAND: assert property (wr_take && haddr[11:0] == 12'h01c ##1 clk_en |=>
		crystal_band_select == $past(hwdata[3:2]) && crystal_drive_strength == $past(hwdata[1:0]))
		else $error("band or drive not loaded");
	cover property (ext_stable);
	cover property (ext_run_fail);
	cover property (ext_start_fail);
endmodule
bind ocb_oscillator_control_bank ocb_checker i_chk (.core_clk, .resetn, .clk_en, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hwdata, .hrdata, .fast_osc_enable, .ext_osc_enable, .fast_stable,
	.slow_stable, .ext_stable, .ext_run_fail, .ext_start_fail, .crystal_band_select,
	.crystal_drive_strength);

// *** test/tb_top.sv ***
// self-checking bench for the oscillator control bank
`timescale 1ns/1ps
`include "ocb_regs.svh"
module tb_top;
	logic core_clk, resetn, clk_en, hsel, hwrite, hready, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, crystal_band_select, crystal_drive_strength;
	logic [2:0] hsize;
	logic fast_osc_enable, slow_osc_enable, ext_osc_enable, ext_clk, ext_run;
	logic internal_fast_oscillator, internal_slow_clock, internal_fast_clock;
	logic ext_input_mode, input_noise_filter_enable, fast_stable, slow_stable, ext_stable;
	logic ext_run_fail, ext_start_fail;
	logic [10:0] fast_osc_trim;
	logic [9:0] slow_osc_trim;
	logic [7:0] ext_half;
	logic pin_gate;
	int err_total, checked, cyc;
	assign hready = hreadyout;
	ocb_oscillator_control_bank #(.FAST_SETTLE_EDGES(4), .EXT_WAIT_0(16), .EXT_WAIT_1(32),
		.EXT_WAIT_2(64), .EXT_WAIT_3(128), .START_LIM_A_CYC(200), .START_LIM_B_CYC(200),
		.START_LIM_C_CYC(200), .START_LIM_D_CYC(200)) i_dut (.core_clk, .resetn, .clk_en,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp(),
		.hrdata, .fast_osc_enable, .slow_osc_enable, .ext_osc_enable, .internal_fast_oscillator,
		.internal_slow_clock, .crystal_osc_clk(ext_clk), .oscillator_input_pin(ext_clk & pin_gate),
		.fast_osc_trim, .slow_osc_trim, .crystal_band_select, .crystal_drive_strength,
		.ext_input_mode, .input_noise_filter_enable, .internal_fast_clock, .fast_stable,
		.slow_stable, .ext_stable, .ext_run_fail, .ext_start_fail);
	ocb_ext_clock_model i_xtal (.run(ext_run), .half_ns(ext_half), .ext_clk(ext_clk));
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		internal_fast_oscillator = 1'b0;
		forever #32 internal_fast_oscillator = ~internal_fast_oscillator;
	end
	initial
	begin
		internal_slow_clock = 1'b0;
		forever #33 internal_slow_clock = ~internal_slow_clock;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_total = err_total + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		do
			@(posedge core_clk);
		while (hready !== 1'b1);
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic t_reset();
		rd_chk(`OCB_EXT_OFF, 32'h0007_ff22);
		rd_chk(`OCB_FAST_OFF, 32'h0000_2c00);
		rd_chk(`OCB_SLOW_OFF, 32'h0000_0e00);
		chk({30'h0, crystal_drive_strength}, 32'h0000_0002);
		chk({30'h0, crystal_band_select}, 32'h0000_0000);
	endtask
	task automatic t_fields();
		bus(1'b1, `OCB_EXT_OFF, 32'h0008_01cd);
		rd_chk(`OCB_EXT_OFF, 32'h0000_01cd);
		chk({26'h0, input_noise_filter_enable, ext_input_mode, crystal_band_select,
			crystal_drive_strength}, 32'h0000_003d);
		bus(1'b1, `OCB_FAST_OFF, 32'h0000_42a5);
		chk({21'h0, fast_osc_trim}, 32'h0000_02a5);
		bus(1'b1, `OCB_SLOW_OFF, 32'h0000_0155);
		chk({22'h0, slow_osc_trim}, 32'h0000_0155);
		bus(1'b1, 12'h030, 32'hffff_ffff);
		rd_chk(12'h030, 32'h0000_0000);
	endtask
	// clock enable low must stall the bus and freeze the settle state
	task automatic t_hold();
		clk_en <= 1'b0;
		slow_osc_enable <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk({30'h0, hreadyout, slow_stable}, 32'h0000_0001);
		clk_en <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk({31'h0, slow_stable}, 32'h0000_0000);
	endtask
	// crystal path with the noise filter; the pin path is held low to prove the choice
	task automatic t_xtal();
		ext_osc_enable <= 1'b0;
		bus(1'b1, `OCB_SUPV_OFF, 32'h0000_0000);
		ext_half <= 8'h40;
		pin_gate <= 1'b0;
		bus(1'b1, `OCB_EXT_OFF, {13'h0000, 11'h001, 2'b10, 2'b00, 4'he});
		chk({30'h0, input_noise_filter_enable, ext_input_mode}, 32'h0000_0002);
		ext_osc_enable <= 1'b1;
		ext_run <= 1'b1;
		repeat (14) @(posedge ext_clk);
		chk({31'h0, ext_stable}, 32'h0000_0000);
		repeat (3) @(posedge ext_clk);
		chk({31'h0, ext_stable}, 32'h0000_0001);
		@(posedge core_clk);
	endtask
	task automatic t_fast();
		logic [3:0] code[9] = '{4'h6, 4'h8, 4'h9, 4'h5, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
		int dv[9] = '{1, 2, 4, 6, 8, 10, 12, 14, 16};
		realtime t0;
		fast_osc_enable <= 1'b1;
		repeat (16) @(posedge core_clk);
		chk({31'h0, fast_stable}, 32'h0000_0000);
		repeat (32) @(posedge core_clk);
		chk({31'h0, fast_stable}, 32'h0000_0001);
		rd_chk(`OCB_FAST_OFF, 32'h0000_c2a5);
		for (int i = 0; i < 9; i++)
		begin
			bus(1'b1, `OCB_FAST_OFF, {17'h0_0000, code[i], 11'h2a5});
			repeat (2) @(posedge internal_fast_clock);
			t0 = $realtime;
			@(posedge internal_fast_clock);
			chk(32'($rtoi($realtime - t0)), 32'(dv[i] * 64));
			@(posedge core_clk);
		end
		fast_osc_enable <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({31'h0, fast_stable}, 32'h0000_0000);
	endtask
	task automatic t_slow();
		int n[4] = '{6, 18, 66, 258};
		for (int s = 0; s < 4; s++)
		begin
			@(posedge core_clk);
			slow_osc_enable <= 1'b0;
			bus(1'b1, `OCB_SLOW_OFF, {20'h0_0000, s[1:0], 10'h155});
			chk({31'h0, slow_stable}, 32'h0000_0000);
			slow_osc_enable <= 1'b1;
			repeat (n[s] - 1) @(posedge internal_slow_clock);
			chk({31'h0, slow_stable}, 32'h0000_0000);
			repeat (2) @(posedge internal_slow_clock);
			chk({31'h0, slow_stable}, 32'h0000_0001);
		end
		@(posedge core_clk);
		rd_chk(`OCB_SLOW_OFF, 32'h0000_8d55);
	endtask
	task automatic t_ext();
		int n[4] = '{16, 32, 64, 128};
		ext_run <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			ext_osc_enable <= 1'b0;
			bus(1'b1, `OCB_EXT_OFF, {13'h0000, 11'h001, 2'b01, s[1:0], 4'he});
			chk({31'h0, ext_stable}, 32'h0000_0000);
			ext_osc_enable <= 1'b1;
			repeat (n[s] - 2) @(posedge ext_clk);
			chk({31'h0, ext_stable}, 32'h0000_0000);
			repeat (3) @(posedge ext_clk);
			chk({31'h0, ext_stable}, 32'h0000_0001);
			@(posedge core_clk);
		end
		rd_chk(`OCB_EXT_OFF, 32'h0008_017e);
		bus(1'b1, `OCB_SUPV_OFF, 32'h0000_0001);
		repeat (40) @(posedge core_clk);
		chk({30'h0, ext_run_fail, ext_stable}, 32'h0000_0002);
		rd_chk(`OCB_SUPV_OFF, 32'h0000_0003);
		ext_run <= 1'b0;
		ext_osc_enable <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({31'h0, ext_run_fail}, 32'h0000_0000);
		ext_osc_enable <= 1'b1;
		repeat (190) @(posedge core_clk);
		chk({31'h0, ext_start_fail}, 32'h0000_0000);
		repeat (20) @(posedge core_clk);
		chk({30'h0, ext_start_fail, ext_stable}, 32'h0000_0002);
		rd_chk(`OCB_SUPV_OFF, 32'h0000_0005);
	endtask
	initial
	begin
		resetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		fast_osc_enable = 1'b0;
		slow_osc_enable = 1'b0;
		ext_osc_enable = 1'b0;
		ext_run = 1'b0;
		ext_half = 8'h20;
		pin_gate = 1'b1;
		err_total = 0;
		checked = 0;
		cyc = 0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_fields();
		t_fast();
		t_slow();
		t_hold();
		t_ext();
		t_xtal();
		finish_test();
	end
endmodule
